// [hdl/opsc_defs.vh]
// Purpose: Constants for the oscillator, multiplier and sleep control block.
// Assumes: 32-bit AXI4-Lite register bus, byte addresses.
// Notes:   Offsets, field positions, encodings, reset values and a divider only.
`ifndef OPSC_DEFS_VH
`define OPSC_DEFS_VH

// Register byte offsets.
`define OPSC_OFF_CONFIG   4'h0
`define OPSC_OFF_CONTROL  4'h4
`define OPSC_OFF_COMMAND  4'h8
`define OPSC_OFF_STATUS   4'hc

// Oscillator configuration field encodings.
`define OPSC_CFG_XTAL_X4  4'h6
`define OPSC_CFG_HS       4'h2
`define OPSC_CFG_RC       4'h3
`define OPSC_CFG_RESISTOR_CAPACITOR_IO_MODE     4'h7
`define OPSC_CFG_INTERNAL_OSCILLATOR_BLOCK   4'h8
`define OPSC_CFG_RESET    4'h7

// Control register fields.
`define OPSC_CTL_SCS_LO   0
`define OPSC_CTL_SCS_HI   1
`define OPSC_CTL_PLL_SOFT_ENABLE    2
`define OPSC_CTL_IDLE_ON_SLEEP_SELECT    3
`define OPSC_CTL_WDT      4
`define OPSC_CTL_T1EN     5
`define OPSC_CTL_TWOSPD   6
`define OPSC_CTL_FSCM     7
`define OPSC_CTL_RESET    8'h00

// Command register fields.
`define OPSC_CMD_SLEEP    0
`define OPSC_CMD_WAKE     1

// System clock select encodings.
`define OPSC_SCS_PRIMARY  2'h0
`define OPSC_SCS_SECONDARY_TIMER_OSCILLATOR   2'h1
`define OPSC_SCS_INTERNAL_OSCILLATOR_BLOCK   2'h2

// Quarter-rate output divider.
`define OPSC_QUARTER_DIV  2'h3

`endif

// [hdl/opsc_top.v]
// Purpose: Clock source, x4 multiplier control and Sleep sequencing.
// Assumes: One 50 MHz clock aclk; oscillator readiness arrives as pins.
// Notes:   Oscillator clocks themselves are analog; this logic steers them
//          through enables and selects, and counts a quarter-rate output.
`timescale 1ns/1ps
`include "opsc_defs.vh"

module opsc_top (
   input  wire        aclk,            // System clock, 50 MHz.
   input  wire        aresetn,         // Synchronous reset, active low.
   input  wire [3:0]  s_axi_awaddr,    // Write address.
   input  wire        s_axi_awvalid,   // Write address valid.
   output wire        s_axi_awready,   // Write address ready.
   input  wire [31:0] s_axi_wdata,     // Write data.
   input  wire [3:0]  s_axi_wstrb,     // Write byte strobes.
   input  wire        s_axi_wvalid,    // Write data valid.
   output wire        s_axi_wready,    // Write data ready.
   output reg  [1:0]  s_axi_bresp,     // Write response.
   output reg         s_axi_bvalid,    // Write response valid.
   input  wire        s_axi_bready,    // Write response ready.
   input  wire [3:0]  s_axi_araddr,    // Read address.
   input  wire        s_axi_arvalid,   // Read address valid.
   output wire        s_axi_arready,   // Read address ready.
   output reg  [31:0] s_axi_rdata,     // Read data.
   output reg  [1:0]  s_axi_rresp,     // Read response.
   output reg         s_axi_rvalid,    // Read data valid.
   input  wire        s_axi_rready,    // Read data ready.
   input  wire        osc_input_clock, // Oscillator input pin level.
   input  wire        primary_ready,   // Primary oscillator stable, pin.
   input  wire        internal_oscillator_block_ready,    // Internal block stable, pin.
   input  wire        secondary_timer_oscillator_ready,    // Timer oscillator stable, pin.
   input  wire        wake_event,      // Interrupt, reset or watchdog wake.
   input  wire        wdt_timeout,     // Watchdog time-out.
   input  wire        port_a_bit_six_out, // Port data for the shared pin.
   input  wire        port_a_bit_six_oe,  // Port drive enable for the pin.
   output reg         oscillator_output_pin_o,  // Shared pin output.
   output reg         oscillator_output_pin_oe, // Shared pin drive enable.
   output reg         primary_osc_enable,  // Primary oscillator runs.
   output reg         pll_enable,          // Multiplier enabled.
   output reg         pll_on_crystal,      // Multiplier input is crystal.
   output reg         low_freq_internal_rc_enable,        // Low RC runs.
   output reg         secondary_timer_oscillator_enable,  // Timer osc runs.
   output reg         internal_oscillator_block_enable,   // Block runs.
   output reg  [1:0]  active_clock_source, // Source clocking the device.
   output reg         cpu_clock_enable,    // Processor clock gate.
   output reg         periph_clock_enable  // Peripheral clock gate.
);

   localparam ST_RUN   = 2'h0;
   localparam ST_IDLE  = 2'h1;
   localparam ST_SLEEP = 2'h2;
   localparam ST_WAKE  = 2'h3;

   reg  [3:0] oscillator_config_field;
   reg  [7:0] control;
   reg  [1:0] state;
   reg  [1:0] next_state;
   reg        primary_clock_running_flag;
   reg        internal_oscillator_block_flag;
   reg        secondary_timer_oscillator_flag;
   reg        on_internal_oscillator_block_fallback;
   reg  [2:0] sync_osc;
   reg  [2:0] sync_pri;
   reg  [2:0] sync_int;
   reg  [2:0] sync_t1;
   reg  [2:0] sync_wake;
   reg        osc_level;
   reg        pri_level;
   reg        int_level;
   reg        t1_level;
   reg        wake_level;
   reg        osc_prev;
   reg  [1:0] quarter_cnt;
   reg        quarter_rate_clock_out;
   reg        aw_held;
   reg        w_held;
   reg  [3:0] aw_addr;
   reg [31:0] w_data;
   reg  [3:0] w_strb;

   wire [1:0] system_clock_select = control[`OPSC_CTL_SCS_HI:`OPSC_CTL_SCS_LO];
   wire       pll_soft_enable     = control[`OPSC_CTL_PLL_SOFT_ENABLE];
   wire       idle_on_sleep_select = control[`OPSC_CTL_IDLE_ON_SLEEP_SELECT];
   wire       crystal_times_four_mode =
              (oscillator_config_field == `OPSC_CFG_XTAL_X4);
   wire       resistor_capacitor_mode    = (oscillator_config_field == `OPSC_CFG_RC);
   wire       resistor_capacitor_io_mode = (oscillator_config_field == `OPSC_CFG_RESISTOR_CAPACITOR_IO_MODE);
   wire       internal_oscillator_block_primary = (oscillator_config_field == `OPSC_CFG_INTERNAL_OSCILLATOR_BLOCK);
   wire       do_write = aw_held & w_held & ~s_axi_bvalid;
   wire       cmd_write = do_write & (aw_addr == `OPSC_OFF_COMMAND) & w_strb[0];
   wire       sleep_cmd = cmd_write & w_data[`OPSC_CMD_SLEEP];
   wire       wake_any  = wake_level | wdt_timeout |
                          (cmd_write & w_data[`OPSC_CMD_WAKE]);
   wire       fast_wake = control[`OPSC_CTL_TWOSPD] | control[`OPSC_CTL_FSCM];
   wire       src_ready = (system_clock_select == `OPSC_SCS_PRIMARY) ? pri_level :
                          (system_clock_select == `OPSC_SCS_SECONDARY_TIMER_OSCILLATOR)  ? t1_level :
                          int_level;

   assign s_axi_awready = ~aw_held;
   assign s_axi_wready  = ~w_held;
   assign s_axi_arready = ~s_axi_rvalid;

   // Pin inputs pass three flops; a change counts when the last two agree.
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync_osc   <= 3'h0;
         sync_pri   <= 3'h0;
         sync_int   <= 3'h0;
         sync_t1    <= 3'h0;
         sync_wake  <= 3'h0;
         osc_level  <= 1'b0;
         pri_level  <= 1'b0;
         int_level  <= 1'b0;
         t1_level   <= 1'b0;
         wake_level <= 1'b0;
      end else begin
         sync_osc  <= {sync_osc[1:0], osc_input_clock};
         sync_pri  <= {sync_pri[1:0], primary_ready};
         sync_int  <= {sync_int[1:0], internal_oscillator_block_ready};
         sync_t1   <= {sync_t1[1:0], secondary_timer_oscillator_ready};
         sync_wake <= {sync_wake[1:0], wake_event};
         if (sync_osc[2] == sync_osc[1]) osc_level <= sync_osc[2];
         if (sync_pri[2] == sync_pri[1]) pri_level <= sync_pri[2];
         if (sync_int[2] == sync_int[1]) int_level <= sync_int[2];
         if (sync_t1[2] == sync_t1[1]) t1_level <= sync_t1[2];
         if (sync_wake[2] == sync_wake[1]) wake_level <= sync_wake[2];
      end
   end

   // Write channel: address and data are held separately, either order.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         aw_addr  <= 4'h0;
         w_data   <= 32'h0;
         w_strb   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         oscillator_config_field <= `OPSC_CFG_RESET;
         control  <= `OPSC_CTL_RESET;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            case (aw_addr)
               `OPSC_OFF_CONFIG:
                  if (w_strb[0]) oscillator_config_field <= w_data[3:0];
               `OPSC_OFF_CONTROL:
                  if (w_strb[0]) control <= w_data[7:0];
               `OPSC_OFF_COMMAND, `OPSC_OFF_STATUS: ;
               default: s_axi_bresp <= 2'h2;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
      end
   end

   // Read channel answers one cycle after the address is taken.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         case (s_axi_araddr)
            `OPSC_OFF_CONFIG:  s_axi_rdata <= {28'h0, oscillator_config_field};
            `OPSC_OFF_CONTROL: s_axi_rdata <= {24'h0, control};
            `OPSC_OFF_COMMAND: s_axi_rdata <= 32'h0;
            `OPSC_OFF_STATUS:
               s_axi_rdata <= {25'h0, state, active_clock_source, secondary_timer_oscillator_flag,
                               internal_oscillator_block_flag, primary_clock_running_flag};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end
   end

   // Power-mode sequencing; sleep wins no clock switch and waits on wake.
   always @* begin
      next_state = state;
      case (state)
         ST_RUN:
            if (sleep_cmd) next_state = idle_on_sleep_select ? ST_IDLE : ST_SLEEP;
         ST_IDLE:
            if (wake_any) next_state = ST_RUN;
         ST_SLEEP:
            if (wake_any) next_state = ST_WAKE;
         ST_WAKE:
            if (fast_wake || src_ready) next_state = ST_RUN;
         default: next_state = ST_RUN;
      endcase
   end

   // State, status flags and fallback tracking; control is never touched here.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_RUN;
         primary_clock_running_flag <= 1'b0;
         internal_oscillator_block_flag <= 1'b0;
         secondary_timer_oscillator_flag <= 1'b0;
         on_internal_oscillator_block_fallback <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state == ST_SLEEP) begin
            primary_clock_running_flag <= 1'b0;
            internal_oscillator_block_flag <= 1'b0;
            secondary_timer_oscillator_flag <= 1'b0;
         end else begin
            if (state == ST_WAKE && next_state == ST_RUN)
               on_internal_oscillator_block_fallback <= fast_wake & ~src_ready;
            else if (on_internal_oscillator_block_fallback && src_ready)
               on_internal_oscillator_block_fallback <= 1'b0;
            primary_clock_running_flag <= (state != ST_WAKE) && !on_internal_oscillator_block_fallback &&
               (system_clock_select == `OPSC_SCS_PRIMARY) && pri_level;
            internal_oscillator_block_flag <= (state != ST_WAKE) && int_level &&
               (on_internal_oscillator_block_fallback || system_clock_select == `OPSC_SCS_INTERNAL_OSCILLATOR_BLOCK);
            secondary_timer_oscillator_flag <= (state != ST_WAKE) && !on_internal_oscillator_block_fallback && t1_level &&
               (system_clock_select == `OPSC_SCS_SECONDARY_TIMER_OSCILLATOR);
         end
      end
   end

   // Quarter-rate output: toggles every second rising edge of the RC input.
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_prev <= 1'b0;
         quarter_cnt <= 2'h0;
         quarter_rate_clock_out <= 1'b0;
      end else begin
         osc_prev <= osc_level;
         if (osc_level && !osc_prev && state != ST_SLEEP) begin
            quarter_cnt <= quarter_cnt + 2'h1;
            if (quarter_cnt[0]) quarter_rate_clock_out <= ~quarter_rate_clock_out;
         end
      end
   end

   // Oscillator enables, multiplier steering and clock gates, registered.
   always @(posedge aclk) begin
      if (!aresetn) begin
         primary_osc_enable <= 1'b0;
         pll_enable <= 1'b0;
         pll_on_crystal <= 1'b0;
         low_freq_internal_rc_enable <= 1'b0;
         secondary_timer_oscillator_enable <= 1'b0;
         internal_oscillator_block_enable <= 1'b0;
         active_clock_source <= `OPSC_SCS_PRIMARY;
         cpu_clock_enable <= 1'b0;
         periph_clock_enable <= 1'b0;
         oscillator_output_pin_o <= 1'b0;
         oscillator_output_pin_oe <= 1'b0;
      end else begin
         primary_osc_enable <= (state != ST_SLEEP);
         pll_on_crystal <= crystal_times_four_mode;
         pll_enable <= (state != ST_SLEEP) && (crystal_times_four_mode ||
                       (internal_oscillator_block_primary && pll_soft_enable));
         low_freq_internal_rc_enable <= control[`OPSC_CTL_WDT];
         secondary_timer_oscillator_enable <= control[`OPSC_CTL_T1EN];
         internal_oscillator_block_enable <= (state != ST_SLEEP) &&
            (internal_oscillator_block_primary || on_internal_oscillator_block_fallback || (state == ST_WAKE && fast_wake) ||
             system_clock_select == `OPSC_SCS_INTERNAL_OSCILLATOR_BLOCK);
         active_clock_source <= on_internal_oscillator_block_fallback ? `OPSC_SCS_INTERNAL_OSCILLATOR_BLOCK : system_clock_select;
         cpu_clock_enable <= (state == ST_RUN);
         periph_clock_enable <= (state == ST_RUN) || (state == ST_IDLE);
         if (resistor_capacitor_mode) begin
            oscillator_output_pin_o  <= quarter_rate_clock_out;
            oscillator_output_pin_oe <= 1'b1;
         end else if (resistor_capacitor_io_mode) begin
            oscillator_output_pin_o  <= port_a_bit_six_out;
            oscillator_output_pin_oe <= port_a_bit_six_oe;
         end else begin
            oscillator_output_pin_o  <= 1'b0;
            oscillator_output_pin_oe <= 1'b0;
         end
      end
   end

endmodule // opsc_top

// [verification/opsc_chk_asserts.sv]
// Purpose: Bus handshake and clock gating checks for the sleep control block.
// Assumes: Sees top-level ports only; one clock domain.
// Notes:   Bound to opsc_top below the module.
`timescale 1ns/1ps
module opsc_chk (
   input wire        aclk,                // Clock.
   input wire        aresetn,             // Reset, active low.
   input wire        s_axi_awready,       // Address ready.
   input wire        s_axi_bvalid,        // Response valid.
   input wire        s_axi_bready,        // Response ready.
   input wire [1:0]  s_axi_bresp,         // Response.
   input wire        s_axi_arvalid,       // Read address valid.
   input wire        s_axi_arready,       // Read address ready.
   input wire        s_axi_rvalid,        // Read valid.
   input wire        s_axi_rready,        // Read ready.
   input wire [31:0] s_axi_rdata,         // Read data.
   input wire        primary_ready,       // Primary stable.
   input wire        primary_osc_enable,  // Primary runs.
   input wire        pll_enable,          // Multiplier on.
   input wire [1:0]  active_clock_source, // Clocking source.
   input wire        cpu_clock_enable,    // Processor gate.
   input wire        periph_clock_enable  // Peripheral gate.
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Sleep starts where the peripheral gate falls; Idle never drops it.
   sequence sleep_entry;
      $fell(periph_clock_enable);
   endsequence
   // Restart of the processor clock, clear of any reset release.
   sequence cpu_restart;
      $rose(cpu_clock_enable) && $past(aresetn, 4);
   endsequence

   bvalid_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rvalid_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken before response");
   gate_order_a: assert property (!periph_clock_enable |-> !cpu_clock_enable)
      else $error("processor clocked without peripherals");
   primary_wait_a: assert property (
      cpu_restart ##0 (active_clock_source == 2'h0) |-> $past(primary_ready, 3))
      else $error("clocks returned before primary ready");
   sleep_stop_a: assert property (
      sleep_entry |-> ##[0:2] (!primary_osc_enable && !pll_enable))
      else $error("oscillator kept running in sleep");
   sleep_hold_a: assert property (
      sleep_entry |-> (!cpu_clock_enable && !periph_clock_enable) [*3])
      else $error("clocks not held off in sleep");
endmodule // opsc_chk

bind opsc_top opsc_chk chk (.*);

// [verification/opsc_osc_model.sv]
// Purpose: Behavioural crystal, RC, internal and timer oscillators.
// Assumes: Ready follows each enable after a start-up count of aclk cycles.
// Notes:   A stopped oscillator holds its pin low and drops ready at once.
`timescale 1ns/1ps
module opsc_osc_model #(
   parameter int PRI_START = 40, // Crystal start-up, cycles.
   parameter int RC_HALF   = 6   // RC half period, cycles.
) (
   input  wire  aclk,                                     // Clock.
   input  wire  primary_osc_enable,                       // Primary runs.
   input  wire  internal_oscillator_block_enable,         // Block runs.
   input  wire  secondary_timer_oscillator_enable,        // Timer runs.
   output logic osc_input_clock = 1'b0,                   // RC level.
   output logic primary_ready = 1'b0,                     // Primary stable.
   output logic internal_oscillator_block_ready = 1'b0,                      // Block stable.
   output logic secondary_timer_oscillator_ready = 1'b0                       // Timer stable.
);
   int pri_cnt = 0, rc_cnt = 0, blk_cnt = 0, tmr_cnt = 0;

   // Slow crystal start-up lets a wake be seen waiting for it.
   always @(posedge aclk) begin
      pri_cnt <= primary_osc_enable ? pri_cnt + 1 : 0;
      blk_cnt <= internal_oscillator_block_enable ? blk_cnt + 1 : 0;
      tmr_cnt <= secondary_timer_oscillator_enable ? tmr_cnt + 1 : 0;
      primary_ready <= primary_osc_enable && pri_cnt >= PRI_START;
      internal_oscillator_block_ready <= internal_oscillator_block_enable && blk_cnt >= 2;
      secondary_timer_oscillator_ready <= secondary_timer_oscillator_enable && tmr_cnt >= 20;
      rc_cnt <= (rc_cnt == RC_HALF - 1 || !primary_osc_enable) ? 0 : rc_cnt + 1;
      if (!primary_osc_enable) osc_input_clock <= 1'b0;
      else if (rc_cnt == RC_HALF - 1) osc_input_clock <= ~osc_input_clock;
   end
endmodule // opsc_osc_model

// [verification/tb_top.sv]
// Purpose: Register-driven tests of clock modes, multiplier and Sleep.
// Assumes: AXI4-Lite master tasks; oscillator model on the far side.
// Notes:   Outputs are sampled at the falling edge, clear of updates.
`timescale 1ns/1ps
`include "opsc_defs.vh"
module tb_top;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_bvalid;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_arready;
   logic        s_axi_rvalid, wake_event, wdt_timeout, port_a_bit_six_out, port_a_bit_six_oe;
   logic        osc_input_clock, primary_ready, internal_oscillator_block_ready, secondary_timer_oscillator_ready, pll_enable;
   logic        oscillator_output_pin_o, oscillator_output_pin_oe, primary_osc_enable;
   logic        pll_on_crystal, low_freq_internal_rc_enable, secondary_timer_oscillator_enable;
   logic        internal_oscillator_block_enable, cpu_clock_enable, periph_clock_enable, p_i, p_o;
   logic [1:0]  s_axi_bresp, s_axi_rresp, active_clock_source, rsp;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   int          failures = 0, n_checks = 0, k, n_i, n_o;
   // Multiplier cases: configuration, control, expected enable and crystal input.
   logic [13:0] pll_tbl [5] = '{{4'h6, 8'h00, 2'b11}, {4'h6, 8'h04, 2'b11},
                                {4'h2, 8'h04, 2'b00}, {4'h8, 8'h04, 2'b10}, {4'h8, 8'h00, 2'b00}};

   opsc_top dut (.*);
   opsc_osc_model #(.PRI_START(40), .RC_HALF(6)) osc (.*);

   // Free-running 50 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask

   // One AXI transfer; handshakes are judged on values settled before the edge.
   task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
      bit aw_t, w_t, ar_t, rv, done;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      done = 1'b0;
      while (!done) begin
         @(negedge aclk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         ar_t = s_axi_arvalid && s_axi_arready;
         rv = wr ? s_axi_bvalid : s_axi_rvalid;
         done = rv && (wr ? s_axi_bready : s_axi_rready);
         rd = s_axi_rdata;
         rsp = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         if (ar_t) s_axi_arvalid <= 1'b0;
         s_axi_bready <= wr && rv && !done;
         s_axi_rready <= !wr && rv && !done;
      end
   endtask

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd & m);
      chk({what, " resp"}, 2'h0, rsp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge aclk);
   endtask

   task automatic wait_cpu(input int lim);
      for (int i = 0; i < lim && cpu_clock_enable !== 1'b1; i++) @(negedge aclk);
   endtask

   task automatic give_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // A hang is cut short well beyond the thousand or so cycles the tests need.
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      give_verdict();
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {wake_event, wdt_timeout, port_a_bit_six_out, port_a_bit_six_oe} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk("config", `OPSC_OFF_CONFIG, 32'hf, {28'h0, `OPSC_CFG_RESET});
      rd_chk("control", `OPSC_OFF_CONTROL, 32'hff, 32'h0);
      rd_chk("command", `OPSC_OFF_COMMAND, 32'hffffffff, 32'h0);
      // Unaligned offsets are unmapped, so both channels answer with a slave error.
      bus(1'b0, 4'h2, 32'h0);
      chk("read resp", 2'h2, rsp);
      bus(1'b1, 4'h6, 32'h0);
      chk("write resp", 2'h2, rsp);
      // Port drive passes to the shared pin in RC with I/O mode.
      for (k = 0; k < 4; k++) begin
         @(posedge aclk);
         port_a_bit_six_out <= k[0];
         port_a_bit_six_oe <= k[1];
         cyc(4);
         chk("pin enable", k[1], oscillator_output_pin_oe);
         if (k[1]) chk("pin data", k[0], oscillator_output_pin_o);
      end
      // RC mode: count rising edges of input and pin over a window.
      bus(1'b1, `OPSC_OFF_CONFIG, {28'h0, `OPSC_CFG_RC});
      cyc(8);
      n_i = 0;
      n_o = 0;
      for (k = 0; k < 480; k++) begin
         p_i = osc_input_clock;
         p_o = oscillator_output_pin_o;
         @(negedge aclk);
         n_i += int'(osc_input_clock && !p_i);
         n_o += int'(oscillator_output_pin_o && !p_o);
      end
      chk("quarter rate", 1, n_o * 4 >= n_i - 4 && n_o * 4 <= n_i + 4);
      chk("rc drives pin", 1, oscillator_output_pin_oe);
      for (k = 0; k < 5; k++) begin
         bus(1'b1, `OPSC_OFF_CONTROL, {24'h0, pll_tbl[k][9:2]});
         bus(1'b1, `OPSC_OFF_CONFIG, {28'h0, pll_tbl[k][13:10]});
         cyc(4);
         chk("pll on crystal", pll_tbl[k][0], pll_on_crystal);
         chk("pll", pll_tbl[k][1], pll_enable);
      end
      // Sleep on crystal x4 with watchdog and timer oscillator kept.
      bus(1'b1, `OPSC_OFF_CONFIG, {28'h0, `OPSC_CFG_XTAL_X4});
      bus(1'b1, `OPSC_OFF_CONTROL, 32'h30);
      cyc(60);
      bus(1'b1, `OPSC_OFF_COMMAND, 32'h1);
      cyc(3);
      chk("sleep gates", 2'b00, {cpu_clock_enable, periph_clock_enable});
      chk("sleep osc", 2'b00, {primary_osc_enable, pll_enable});
      chk("wdt rc kept", 1, low_freq_internal_rc_enable);
      chk("timer osc kept", 1, secondary_timer_oscillator_enable);
      rd_chk("sleep status", `OPSC_OFF_STATUS, 32'h67, 32'h40);
      @(posedge aclk);
      wake_event <= 1'b1;
      repeat (3) @(posedge aclk);
      wake_event <= 1'b0;
      cyc(12);
      chk("wake waits", 0, cpu_clock_enable);
      wait_cpu(300);
      chk("ready at wake", 2'b11, {cpu_clock_enable, primary_ready});
      chk("pll back", 1, pll_enable);
      rd_chk("wake status", `OPSC_OFF_STATUS, 32'h61, 32'h01);
      rd_chk("wake control", `OPSC_OFF_CONTROL, 32'hff, 32'h30);
      // Two-speed wake by watchdog runs on the internal block first.
      bus(1'b1, `OPSC_OFF_CONTROL, 32'h40);
      bus(1'b1, `OPSC_OFF_COMMAND, 32'h1);
      cyc(10);
      @(posedge aclk);
      wdt_timeout <= 1'b1;
      @(posedge aclk);
      wdt_timeout <= 1'b0;
      wait_cpu(30);
      chk("fast wake", 2'b10, {cpu_clock_enable, primary_ready});
      chk("on block", `OPSC_SCS_INTERNAL_OSCILLATOR_BLOCK, active_clock_source);
      chk("block on", 1, internal_oscillator_block_enable);
      cyc(80);
      rd_chk("primary running", `OPSC_OFF_STATUS, 32'h79, 32'h01);
      // Idle keeps peripherals clocked; software wake restores the processor.
      bus(1'b1, `OPSC_OFF_CONTROL, 32'h08);
      bus(1'b1, `OPSC_OFF_COMMAND, 32'h1);
      cyc(3);
      chk("idle gates", 2'b01, {cpu_clock_enable, periph_clock_enable});
      rd_chk("idle status", `OPSC_OFF_STATUS, 32'h61, 32'h21);
      bus(1'b1, `OPSC_OFF_COMMAND, 32'h2);
      cyc(4);
      chk("idle wake", 1, cpu_clock_enable);
      rd_chk("idle control", `OPSC_OFF_CONTROL, 32'hff, 32'h08);
      give_verdict();
   end
endmodule // tb_top
